// [hdl/tmw_timer8.sv]
// 8-bit timer/counter with waveform modes and two compare-output channels.
// Assumes register strobes and the external count pin are synchronous to mclk.
// Summary of operation
// RQ1: Everything runs on mclk; the timer tick is only a count enable.
// RQ2: Nonzero action field makes the compare output take over its pin.
// RQ3: Software sets pin direction to output; this block only signals override.
// RQ4: Non-PWM channel A: off, toggle, clear or set on match.
// RQ5: Non-PWM channel B uses the same four actions as channel A.
// RQ6: Fast PWM A: 10 clear-match/set-bottom, 11 inverse, 01 toggles if high mode bit.
// RQ7: Fast PWM B: 01 reserved, 10 clear-match/set-bottom, 11 inverse.
// RQ8: Fast PWM, compare equals top with action bit 1: act at bottom only.
// RQ9: Phase PWM A: 10 clear up/set down, 11 inverse, 01 toggles if high bit.
// RQ10: Phase PWM B: 01 reserved, 10 clear up/set down, 11 inverse.
// RQ11: Phase PWM, compare equals top with action bit 1: act at top.
// RQ12: Control A bits 3:2 always read zero.
// RQ13: Mode is control A bits 1:0 plus high bit from control B.
// RQ14: Mode decode selects counting style and top source, 4 and 6 reserved.
// RQ15: Compare loads immediately in non-PWM, at top in PWM modes.
// RQ16: Overflow flag at max in 0,2,3, bottom in 1,5, top in 7.
// RQ17: Tick source: stopped, /1, /8, /64, /256, /1024, pin fall or rise.
// RQ18: Fast PWM counts up to top then clears on the next tick.
// RQ19: Phase PWM holds top one tick, then counts down to bottom.
// RQ20: Reset clears control: normal mode, both outputs disconnected.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tmw_timer8 (
  input wire logic mclk, // I/O clock
  input wire logic rst, // Async reset, active high
  input wire tmw_pkg::tmw_bus_s bus, // Register port request
  input wire logic extPin, // External count pin
  output logic [7:0] rdata, // Read data, cycle after read strobe
  output logic compareOutA, // Waveform A
  output logic compareOutB, // Waveform B
  output logic pinOverrideA, // Waveform A owns its pin
  output logic pinOverrideB, // Waveform B owns its pin
  output logic [2:0] flagsOut // Match B, match A, overflow
);
  import tmw_pkg::*;

  tmw_state_s q;
  tmw_state_s d;
  tmw_wave_mode_e mode;
  logic tick;
  logic [7:0] top;
  logic atTop;
  logic matchA;
  logic matchB;
  logic countWrite;
  logic ovfEvent;
  logic [2:0] flagSet;
  logic [1:0] actCodeA;
  logic [1:0] actCodeB;

  function automatic logic isPwm(input tmw_wave_mode_e m);
    isPwm = (m == MODE_PHASE_FF) || (m == MODE_PHASE_A) || (m == MODE_FAST_FF) || (m == MODE_FAST_A);
  endfunction : isPwm

  function automatic logic isFast(input tmw_wave_mode_e m);
    isFast = (m == MODE_FAST_FF) || (m == MODE_FAST_A);
  endfunction : isFast

  function automatic logic isPhase(input tmw_wave_mode_e m);
    isPhase = (m == MODE_PHASE_FF) || (m == MODE_PHASE_A);
  endfunction : isPhase

  function automatic logic preDone(input logic [9:0] p, input logic [9:0] mask);
    preDone = ((p & mask) == mask);
  endfunction : preDone

  // Next output level for one channel; toggleOk marks channels where code 01 may toggle in PWM modes
  function automatic logic nextOut(input logic cur, input logic [1:0] code, input tmw_wave_mode_e m,
      input logic match, input logic forceHit, input logic wrapOrTop, input logic cmpIsTop,
      input tmw_dir_e dir, input logic toggleOk);
    logic r;
    r = cur;
    if (!isPwm(m)) begin
      if (match || forceHit) begin
        unique case (code) // [RQ4] [RQ5]
          ACT_TOGGLE: r = ~cur;
          ACT_CLEAR: r = 1'b0;
          ACT_SET: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else if (code == ACT_TOGGLE) begin
      if (match && toggleOk) begin
        r = ~cur; // [RQ6] [RQ9]
      end
    end else if (code[1]) begin
      if (isFast(m)) begin
        if (wrapOrTop) begin
          r = (code == ACT_CLEAR); // [RQ6] [RQ7]
        end else if (match && !cmpIsTop) begin
          r = (code != ACT_CLEAR); // [RQ8]
        end
      end else begin
        if (cmpIsTop) begin
          if (wrapOrTop) begin
            r = (code == ACT_CLEAR); // [RQ11]
          end
        end else if (match) begin
          r = (dir == DIR_UP) ? (code == ACT_SET) : (code == ACT_CLEAR); // [RQ9] [RQ10]
        end
      end
    end
    nextOut = r;
  endfunction : nextOut

  assign mode = tmw_wave_mode_e'({q.waveModeHigh, q.ctrlA[MODE_LOW_HI:MODE_LOW_LO]}); // [RQ13]
  assign actCodeA = q.ctrlA[ACT_A_HI:ACT_A_LO];
  assign actCodeB = q.ctrlA[ACT_B_HI:ACT_B_LO];
  // Reserved modes 4 and 6 fall back to a top of MAX
  assign top = (mode == MODE_CLEAR_ON_MATCH || mode == MODE_PHASE_A || mode == MODE_FAST_A) ?
      q.actA : COUNT_MAX; // [RQ14]
  assign atTop = (q.countValue == top);
  assign countWrite = bus.we && (bus.addr == ADDR_COUNT);

  // Tick is an enable inside the mclk domain, never a clock
  always_comb begin
    unique case (tmw_tick_source_e'(q.tickSel)) // [RQ1] [RQ17]
      SRC_STOP: tick = 1'b0;
      SRC_DIV1: tick = 1'b1;
      SRC_DIV8: tick = preDone(q.pre, PRE_MASK_8);
      SRC_DIV64: tick = preDone(q.pre, PRE_MASK_64);
      SRC_DIV256: tick = preDone(q.pre, PRE_MASK_256);
      SRC_DIV1024: tick = preDone(q.pre, PRE_MASK_1024);
      SRC_EXT_FALL: tick = q.extPrev && !extPin;
      SRC_EXT_RISE: tick = !q.extPrev && extPin;
    endcase
  end

  // A count write suppresses the match on the following tick
  assign matchA = tick && !q.blockMatch && (q.countValue == q.actA);
  assign matchB = tick && !q.blockMatch && (q.countValue == q.actB);

  always_comb begin
    unique case (mode) // [RQ16]
      MODE_PHASE_FF, MODE_PHASE_A: ovfEvent = tick && (q.dir == DIR_DOWN) && (q.countValue == COUNT_BOTTOM);
      MODE_FAST_A: ovfEvent = tick && atTop;
      default: ovfEvent = tick && (q.countValue == COUNT_MAX);
    endcase
  end

  always_comb begin
    flagSet = 3'h0;
    flagSet[FLAG_MATCH_A] = matchA;
    flagSet[FLAG_MATCH_B] = matchB;
    flagSet[FLAG_OVF] = ovfEvent;
  end

  always_comb begin
    d = q;
    d.extPrev = extPin;
    d.pre = (q.tickSel == SRC_STOP) ? 10'h000 : q.pre + 10'h001;
    // Counting
    if (tick) begin
      if (isPhase(mode)) begin
        if (q.dir == DIR_UP) begin
          if (atTop) begin
            d.dir = DIR_DOWN; // [RQ19]
            d.countValue = q.countValue - 8'h01;
          end else begin
            d.countValue = q.countValue + 8'h01;
          end
        end else begin
          if (q.countValue == COUNT_BOTTOM) begin
            d.dir = DIR_UP;
            d.countValue = q.countValue + 8'h01;
          end else begin
            d.countValue = q.countValue - 8'h01;
          end
        end
      end else if (isFast(mode) || mode == MODE_CLEAR_ON_MATCH) begin
        d.countValue = atTop ? COUNT_BOTTOM : q.countValue + 8'h01; // [RQ18]
        d.dir = DIR_UP;
      end else begin
        d.countValue = q.countValue + 8'h01;
        d.dir = DIR_UP;
      end
    end
    d.blockMatch = tick ? 1'b0 : q.blockMatch;
    // Compare reload: buffered values only reach the comparator at top in PWM
    if (!isPwm(mode)) begin
      d.actA = q.bufA; // [RQ15]
      d.actB = q.bufB;
    end else if (tick && atTop) begin
      d.actA = q.bufA; // [RQ15]
      d.actB = q.bufB;
    end
    // Waveforms
    d.outA = nextOut(q.outA, actCodeA, mode, matchA,
        bus.we && bus.addr == ADDR_CTRL_B && bus.wdata[FORCE_A_BIT],
        tick && atTop, q.actA == top, q.dir, q.waveModeHigh);
    d.outB = nextOut(q.outB, actCodeB, mode, matchB,
        bus.we && bus.addr == ADDR_CTRL_B && bus.wdata[FORCE_B_BIT],
        tick && atTop, q.actB == top, q.dir, 1'b0);
    // Flags: hardware set wins over a write-one clear
    d.flags = q.flags | flagSet;
    if (bus.we && bus.addr == ADDR_FLAGS) begin
      d.flags = (q.flags & ~bus.wdata[2:0]) | flagSet;
    end
    // Register writes
    if (bus.we) begin
      unique case (bus.addr)
        ADDR_CTRL_A: d.ctrlA = bus.wdata & 8'hf3; // [RQ12]
        ADDR_CTRL_B: begin
          d.waveModeHigh = bus.wdata[MODE_HIGH_BIT];
          d.tickSel = bus.wdata[SEL_HI:SEL_LO];
        end
        ADDR_COUNT: begin
          d.countValue = bus.wdata;
          d.blockMatch = 1'b1;
        end
        ADDR_CMP_A: begin
          d.bufA = bus.wdata;
          if (!isPwm(mode)) begin
            d.actA = bus.wdata; // [RQ15]
          end
        end
        ADDR_CMP_B: begin
          d.bufB = bus.wdata;
          if (!isPwm(mode)) begin
            d.actB = bus.wdata;
          end
        end
        default: ;
      endcase
    end
    // Read data stands only in the cycle after the strobe
    d.rdata = 8'h00;
    if (bus.re) begin
      unique case (bus.addr)
        ADDR_CTRL_A: d.rdata = q.ctrlA & 8'hf3; // [RQ12]
        ADDR_CTRL_B: d.rdata = {4'h0, q.waveModeHigh, q.tickSel};
        ADDR_COUNT: d.rdata = q.countValue;
        ADDR_CMP_A: d.rdata = q.bufA;
        ADDR_CMP_B: d.rdata = q.bufB;
        ADDR_FLAGS: d.rdata = {5'h00, q.flags};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ctrlA <= CTRL_RESET; // [RQ20]
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign compareOutA = q.outA;
  assign compareOutB = q.outB;
  // Ownership only; the pin driver still waits on its direction bit
  assign pinOverrideA = (actCodeA != ACT_OFF); // [RQ2]
  assign pinOverrideB = (actCodeB != ACT_OFF); // [RQ2]
  assign flagsOut = q.flags;

  a_stop_no_tick: assert property (@(posedge mclk) disable iff (rst) // [RQ17]
    (q.tickSel == SRC_STOP) |-> !tick) else $error("tick while stopped");
  a_ovf_normal: assert property (@(posedge mclk) disable iff (rst) // [RQ16]
    (tick && mode == MODE_NORMAL && q.countValue == COUNT_MAX) |=> q.flags[FLAG_OVF])
    else $error("overflow flag missed at max");
  a_fast_wrap: assert property (@(posedge mclk) disable iff (rst) // [RQ18]
    (tick && isFast(mode) && atTop && !countWrite) |=> (q.countValue == COUNT_BOTTOM))
    else $error("fast pwm did not wrap");
  a_phase_turn: assert property (@(posedge mclk) disable iff (rst) // [RQ19]
    (tick && isPhase(mode) && q.dir == DIR_UP && atTop && !countWrite && !(bus.we && bus.addr == ADDR_CTRL_A))
    |=> (q.dir == DIR_DOWN && q.countValue == $past(q.countValue) - 8'h01))
    else $error("phase pwm did not turn at top");
  a_rsv_read_zero: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
    (bus.re && bus.addr == ADDR_CTRL_A) |=> (rdata[RSV_HI:RSV_LO] == 2'h0))
    else $error("reserved bits read nonzero");
  a_pwm_buffer: assert property (@(posedge mclk) disable iff (rst) // [RQ15]
    (isPwm(mode) && !(tick && atTop) && !(bus.we && bus.addr == ADDR_CTRL_A)) |=> $stable(q.actA))
    else $error("compare changed outside top");
  a_immediate_load: assert property (@(posedge mclk) disable iff (rst) // [RQ15]
    (!isPwm(mode) && bus.we && bus.addr == ADDR_CMP_A) |=> (q.actA == $past(bus.wdata)))
    else $error("compare not loaded immediately");
  a_set_on_match: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
    (!isPwm(mode) && matchA && actCodeA == ACT_SET) |=> compareOutA)
    else $error("output a not set on match");
  a_fast_bottom_b: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
    (isFast(mode) && tick && atTop && actCodeB == ACT_CLEAR) |=> compareOutB)
    else $error("output b not set at bottom");
  a_fast_rsv_b: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
    (isFast(mode) && actCodeB == ACT_TOGGLE) |=> (compareOutB == $past(compareOutB)))
    else $error("reserved code moved output b");
  a_phase_top_a: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
    (isPhase(mode) && tick && atTop && q.actA == top && actCodeA == ACT_CLEAR) |=> compareOutA)
    else $error("phase special case not at top");
  a_phase_bottom: assert property (@(posedge mclk) disable iff (rst) // [RQ19]
    (tick && isPhase(mode) && q.dir == DIR_DOWN && q.countValue == COUNT_BOTTOM && !countWrite)
    |=> (q.dir == DIR_UP && q.countValue == 8'h01))
    else $error("phase pwm did not turn at bottom");
  a_ovf_phase: assert property (@(posedge mclk) disable iff (rst) // [RQ16]
    (tick && isPhase(mode) && q.dir == DIR_DOWN && q.countValue == COUNT_BOTTOM) |=> q.flags[FLAG_OVF])
    else $error("overflow flag missed at bottom");
endmodule : tmw_timer8
`default_nettype wire

// [hdl/tmw_pkg.sv]
// Constants, codes and carriers for the 8-bit timer waveform and compare-output block.
// Assumes a single 125 MHz I/O clock and a plain strobe-based register port.
package tmw_pkg;

  // Register addresses on the plain register port
  localparam logic [2:0] ADDR_CTRL_A = 3'h0;
  localparam logic [2:0] ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] ADDR_COUNT = 3'h2;
  localparam logic [2:0] ADDR_CMP_A = 3'h3;
  localparam logic [2:0] ADDR_CMP_B = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;

  // Control A field positions
  localparam int ACT_A_HI = 7;
  localparam int ACT_A_LO = 6;
  localparam int ACT_B_HI = 5;
  localparam int ACT_B_LO = 4;
  localparam int RSV_HI = 3;
  localparam int RSV_LO = 2;
  localparam int MODE_LOW_HI = 1;
  localparam int MODE_LOW_LO = 0;

  // Control B field positions
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int MODE_HIGH_BIT = 3;
  localparam int SEL_HI = 2;
  localparam int SEL_LO = 0;

  // Flag positions
  localparam int FLAG_MATCH_B = 2;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_OVF = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Prescaler terminal masks
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0, MODE_PHASE_FF = 3'h1, MODE_CLEAR_ON_MATCH = 3'h2, MODE_FAST_FF = 3'h3,
    MODE_RSV4 = 3'h4, MODE_PHASE_A = 3'h5, MODE_RSV6 = 3'h6, MODE_FAST_A = 3'h7
  } tmw_wave_mode_e;

  typedef enum logic [2:0] {
    SRC_STOP = 3'h0, SRC_DIV1 = 3'h1, SRC_DIV8 = 3'h2, SRC_DIV64 = 3'h3,
    SRC_DIV256 = 3'h4, SRC_DIV1024 = 3'h5, SRC_EXT_FALL = 3'h6, SRC_EXT_RISE = 3'h7
  } tmw_tick_source_e;

  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tmw_dir_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } tmw_bus_s;

  typedef struct packed {
    logic [7:0] ctrlA;
    logic waveModeHigh;
    logic [2:0] tickSel;
    logic [7:0] countValue;
    logic [7:0] bufA;
    logic [7:0] bufB;
    logic [7:0] actA;
    logic [7:0] actB;
    tmw_dir_e dir;
    logic outA;
    logic outB;
    logic [2:0] flags;
    logic blockMatch;
    logic [9:0] pre;
    logic extPrev;
    logic [7:0] rdata;
  } tmw_state_s;

endpackage : tmw_pkg

// [tb/tmw_timer8_bench.sv]
// Self-checking bench for the 8-bit timer waveform block.
// Assumes the plain strobe register port and ticks made on the external pin, except in the divide by 8 and undivided tests.
`timescale 1ns/1ns
`default_nettype none
module tmw_timer8_bench;
  import tmw_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  tmw_bus_s busReq = '0;
  logic extPin = 1'b0;
  logic [7:0] rdata;
  logic compareOutA, compareOutB, pinOverrideA, pinOverrideB;
  logic [2:0] flagsOut;
  logic [7:0] rv;
  int fails = 0;
  int nChecks = 0;
  int cycles = 0;

  tmw_timer8 tmw_timer8_inst (
    .mclk(mclk), .rst(rst), .bus(busReq), .extPin(extPin), .rdata(rdata),
    .compareOutA(compareOutA), .compareOutB(compareOutB), .pinOverrideA(pinOverrideA),
    .pinOverrideB(pinOverrideB), .flagsOut(flagsOut)
  );

  always #4 mclk = ~mclk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bit2(input logic a, input logic b, input logic [1:0] exp);
    check({6'h0, a, b}, {6'h0, exp});
  endtask : bit2

  // Idle cycle before each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge mclk);
    busReq <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge mclk);
    busReq <= '0;
    #1 rv = rdata;
  endtask : rd

  // One rising edge on the pin is one tick with source 7
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      extPin <= 1'b1;
      @(posedge mclk);
      extPin <= 1'b0;
    end
    #1;
  endtask : ticks

  task automatic rstDut;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
  endtask : rstDut

  task automatic cnt(input logic [7:0] exp);
    rd(ADDR_COUNT);
    check(rv, exp);
  endtask : cnt

  initial begin
    logic [1:0] codes [5] = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h1};
    logic [1:0] outs [5] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h3};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_CTRL_A);
    check(rv, 8'h00);
    bit2(pinOverrideA, pinOverrideB, 2'h0);
    rd(3'h6);
    check(rv, 8'h00);
    $display("test reset done");

    wr(ADDR_CTRL_A, 8'hff);
    rd(ADDR_CTRL_A);
    check(rv, 8'hf3);
    bit2(pinOverrideA, pinOverrideB, 2'h3);
    wr(ADDR_CTRL_A, 8'h10);
    bit2(pinOverrideA, pinOverrideB, 2'h1);
    $display("test control done");

    // Forced compares show the set, clear and toggle non-PWM actions without counter timing
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL_A, {codes[i], codes[i], 4'h0});
      wr(ADDR_CTRL_B, 8'hc0);
      bit2(compareOutA, compareOutB, outs[i]);
    end
    $display("test force actions done");

    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_CTRL_B, 8'h07);
    wr(ADDR_COUNT, 8'hfd);
    ticks(2);
    check({5'h0, flagsOut}, 8'h00);
    ticks(1);
    check({7'h0, flagsOut[FLAG_OVF]}, 8'h01);
    cnt(8'h00);
    $display("test normal overflow done");

    rstDut();
    wr(ADDR_CTRL_A, 8'h01);
    wr(ADDR_CTRL_B, 8'h07);
    wr(ADDR_COUNT, 8'hfd);
    ticks(3);
    check({5'h0, flagsOut}, 8'h00);
    cnt(8'hfe);
    $display("test phase ff done");

    rstDut();
    wr(ADDR_CMP_A, 8'h02);
    wr(ADDR_CTRL_A, 8'h42);
    wr(ADDR_CTRL_B, 8'h07);
    ticks(3);
    cnt(8'h00);
    // Compare B still holds 0, so the first tick at count 0 flags a B match
    check({5'h0, flagsOut}, 8'h06);
    bit2(compareOutA, pinOverrideA, 2'h3);
    $display("test clear on match done");

    rstDut();
    wr(ADDR_CMP_A, 8'h03);
    wr(ADDR_CMP_B, 8'h01);
    wr(ADDR_CTRL_A, 8'ha3);
    wr(ADDR_CTRL_B, 8'h0f);
    ticks(4);
    cnt(8'h00);
    check({7'h0, flagsOut[FLAG_OVF]}, 8'h01);
    bit2(compareOutA, compareOutB, 2'h3);
    ticks(2);
    cnt(8'h02);
    bit2(compareOutA, compareOutB, 2'h2);
    // New top must wait for the old top before it applies
    wr(ADDR_CMP_A, 8'h05);
    ticks(2);
    cnt(8'h00);
    rd(ADDR_CMP_A);
    check(rv, 8'h05);
    $display("test fast pwm done");

    rstDut();
    wr(ADDR_CMP_A, 8'h04);
    wr(ADDR_CMP_B, 8'h02);
    wr(ADDR_CTRL_A, 8'hb1);
    wr(ADDR_CTRL_B, 8'h0f);
    ticks(4);
    cnt(8'h04);
    ticks(1);
    cnt(8'h03);
    bit2(compareOutA, compareOutB, 2'h3);
    ticks(2);
    bit2(compareOutA, compareOutB, 2'h2);
    ticks(1);
    check({7'h0, flagsOut[FLAG_OVF]}, 8'h00);
    ticks(1);
    check({7'h0, flagsOut[FLAG_OVF]}, 8'h01);
    cnt(8'h01);
    $display("test phase pwm done");

    // Divide by 8 over about 80 clocks, loose bound for start phase
    rstDut();
    wr(ADDR_CTRL_B, 8'h02);
    repeat (80) @(posedge mclk);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT);
    check({7'h0, (rv >= 8'h09) && (rv <= 8'h0b)}, 8'h01);
    $display("test prescaler done");

    // Undivided source ticks once per clock up to the write of source 6, then falling pin edges
    rstDut();
    wr(ADDR_CTRL_B, 8'h01);
    wr(ADDR_CTRL_B, 8'h06);
    cnt(8'h02);
    ticks(3);
    // Last falling tick lands as the read strobe is launched
    cnt(8'h05);
    $display("test undivided and falling pin done");
    end_of_test();
  end
endmodule : tmw_timer8_bench
`default_nettype wire
